// [src/socket_status_change_events.v]
`timescale 1ns/1ns
`include "socket_event_map.vh"
module socket_status_change_events #(
  parameter [31:0] SETUP_RESET = 32'h00000000,
  parameter [31:0] POWER_RESET = 32'h00000000
) (
  input wire refClk,
  input wire reset,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgWriteData,
  output reg [31:0] cfgReadData,
  input wire memWrite,
  input wire memRead,
  input wire [31:0] memAddr,
  input wire [3:0] memByteEnable,
  input wire [31:0] memWriteData,
  output reg [31:0] memReadData,
  output reg memReadValid,
  output wire memHit,
  input wire card_status_field,
  input wire detect_one_status,
  input wire detect_two_status,
  input wire power_cycle_status,
  input wire cardResetPin,
  input wire cardIsCardBus,
  input wire interruptsEnabled,
  output reg status_change_interrupt,
  output wire [31:0] setupOut,
  output wire [31:0] powerOut
);
  localparam NPIN = 5;
  localparam PIN_RESET = 4;
  localparam NEV = `SCE_EVENT_BITS;

  // ******************************************************************
  // state
  // ******************************************************************
  reg [31:`SCE_BASE_LSB] base_q;
  reg [NEV-1:0] flags_q;
  reg [NEV-1:0] flags_d;
  reg [NEV-1:0] enable_q;
  reg [31:0] setup_q;
  reg [31:0] power_q;
  reg [31:0] readWord;
  reg [NEV-1:0] hwSet;
  reg [NEV-1:0] swClear;
  reg [NEV-1:0] swInject;
  reg [NEV-1:0] gated;
  reg [NEV-1:0] enableEff;

  wire [NPIN-1:0] pinLevel;
  wire [NPIN-1:0] pinRise;
  wire [NPIN-1:0] pinFall;
  wire [`SCE_WIN_BITS-1:0] offset;
  wire writeHit;
  wire lowLane;
  wire resetLeave;

  // ******************************************************************
  // socket pin synchronisation
  // ******************************************************************
  pin_edge_sync #(
    .WIDTH(NPIN)
  ) pinSync (
    .refClk(refClk),
    .reset(reset),
    .pinIn({cardResetPin, power_cycle_status, detect_two_status,
            detect_one_status, card_status_field}),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  assign resetLeave = pinFall[PIN_RESET];

  // ******************************************************************
  // configuration space base address
  // ******************************************************************
  always @(posedge refClk) begin
    if (reset) begin
      base_q <= {(32-`SCE_BASE_LSB){1'b0}};
    end else if (cfgWrite && cfgAddr == `SCE_CFG_BASE_OFS) begin
      base_q <= cfgWriteData[31:`SCE_BASE_LSB];
    end
  end

  always @(posedge refClk) begin
    if (reset) begin
      cfgReadData <= `SCE_WORD_ZERO;
    end else if (cfgRead) begin
      if (cfgAddr == `SCE_CFG_BASE_OFS) begin
        cfgReadData <= {base_q, {`SCE_BASE_LSB{1'b0}}};
      end else begin
        cfgReadData <= `SCE_WORD_ZERO;
      end
    end
  end

  // ******************************************************************
  // memory window decode
  // ******************************************************************
  assign memHit = (memAddr[31:`SCE_BASE_LSB] == base_q);
  assign offset = memAddr[`SCE_WIN_BITS-1:0];
  assign writeHit = memWrite && memHit;
  assign lowLane = memByteEnable[0];

  // ******************************************************************
  // hardware event detection
  // ******************************************************************
  always @* begin
    hwSet = {NEV{1'b0}};
    // bit 0: edge choice depends on card type
    if (cardIsCardBus) begin
      hwSet[`SCE_BIT_STATUS] = pinRise[`SCE_BIT_STATUS];
    end else begin
      hwSet[`SCE_BIT_STATUS] = pinRise[`SCE_BIT_STATUS] |
                               pinFall[`SCE_BIT_STATUS];
    end
    hwSet[`SCE_BIT_DETECT1] = pinRise[`SCE_BIT_DETECT1] |
                              pinFall[`SCE_BIT_DETECT1];
    hwSet[`SCE_BIT_DETECT2] = pinRise[`SCE_BIT_DETECT2] |
                              pinFall[`SCE_BIT_DETECT2];
    hwSet[`SCE_BIT_POWER] = pinRise[`SCE_BIT_POWER] |
                            pinFall[`SCE_BIT_POWER];
    // status still asserted when card reset ends
    if (resetLeave) begin
      hwSet[`SCE_BIT_STATUS] = hwSet[`SCE_BIT_STATUS] |
                               pinLevel[`SCE_BIT_STATUS];
      hwSet[`SCE_BIT_DETECT1] = hwSet[`SCE_BIT_DETECT1] |
                                pinLevel[`SCE_BIT_DETECT1];
      hwSet[`SCE_BIT_DETECT2] = hwSet[`SCE_BIT_DETECT2] |
                                pinLevel[`SCE_BIT_DETECT2];
    end
  end

  // ******************************************************************
  // software clear and inject strobes
  // ******************************************************************
  always @* begin
    swClear = {NEV{1'b0}};
    swInject = {NEV{1'b0}};
    if (writeHit && lowLane) begin
      if (offset == `SCE_OFS_FLAGS) begin
        swClear = memWriteData[NEV-1:0];
      end
      if (offset == `SCE_OFS_INJECT) begin
        swInject = memWriteData[NEV-1:0];
      end
    end
  end

  // ******************************************************************
  // flag register, set wins over clear
  // ******************************************************************
  always @* begin
    flags_d = (flags_q & ~swClear) | hwSet | swInject;
  end

  always @(posedge refClk) begin
    if (reset) begin
      flags_q <= `SCE_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ******************************************************************
  // enable, setup and power registers
  // ******************************************************************
  always @(posedge refClk) begin
    if (reset) begin
      enable_q <= `SCE_ENABLE_RESET;
    end else if (writeHit && lowLane && offset == `SCE_OFS_ENABLE) begin
      enable_q <= memWriteData[NEV-1:0];
    end
  end

  always @(posedge refClk) begin
    if (reset) begin
      setup_q <= SETUP_RESET;
      power_q <= POWER_RESET;
    end else begin
      if (writeHit && offset == `SCE_OFS_SETUP) begin
        setup_q <= mergeLanes(setup_q, memWriteData, memByteEnable);
      end
      if (writeHit && offset == `SCE_OFS_POWER) begin
        power_q <= mergeLanes(power_q, memWriteData, memByteEnable);
      end
    end
  end

  function [31:0] mergeLanes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] lanes;
    integer i;
    begin
      mergeLanes = oldWord;
      for (i = 0; i < 4; i = i + 1) begin
        if (lanes[i]) begin
          mergeLanes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  assign setupOut = setup_q;
  assign powerOut = power_q;

  // ******************************************************************
  // interrupt gating
  // ******************************************************************
  always @* begin
    enableEff = enable_q;
    // detect pair allows only when both bits are set
    if (enable_q[`SCE_BIT_DETECT2:`SCE_BIT_DETECT1] != `SCE_DETECT_ON) begin
      enableEff[`SCE_BIT_DETECT2:`SCE_BIT_DETECT1] = 2'h0;
    end
    gated = flags_q & enableEff;
  end

  always @(posedge refClk) begin
    if (reset) begin
      status_change_interrupt <= 1'b0;
    end else begin
      status_change_interrupt <= interruptsEnabled && (|gated);
    end
  end

  // ******************************************************************
  // read path
  // ******************************************************************
  always @* begin
    readWord = `SCE_WORD_ZERO;
    case (offset)
      `SCE_OFS_FLAGS: begin
        readWord[NEV-1:0] = flags_q;
      end
      `SCE_OFS_ENABLE: begin
        readWord[NEV-1:0] = enable_q;
      end
      `SCE_OFS_CONDITION: begin
        readWord[NEV-1:0] = pinLevel[NEV-1:0];
      end
      `SCE_OFS_SETUP: begin
        readWord = setup_q;
      end
      `SCE_OFS_POWER: begin
        readWord = power_q;
      end
      default: begin
        readWord = `SCE_WORD_ZERO;
      end
    endcase
  end

  always @(posedge refClk) begin
    if (reset) begin
      memReadData <= `SCE_WORD_ZERO;
      memReadValid <= 1'b0;
    end else begin
      memReadValid <= memRead && memHit;
      if (memRead && memHit) begin
        memReadData <= readWord;
      end
    end
  end
endmodule

// [src/socket_event_map.vh]
`ifndef SOCKET_EVENT_MAP_VH
`define SOCKET_EVENT_MAP_VH

// ********************************************************************
// configuration space
// ********************************************************************
`define SCE_CFG_BASE_OFS 8'h10
`define SCE_BASE_LSB 12
`define SCE_WIN_BITS 12

// ********************************************************************
// socket register offsets inside the window
// ********************************************************************
`define SCE_OFS_FLAGS 12'h000
`define SCE_OFS_ENABLE 12'h004
`define SCE_OFS_CONDITION 12'h008
`define SCE_OFS_INJECT 12'h00C
`define SCE_OFS_SETUP 12'h010
`define SCE_OFS_RSVD_A 12'h014
`define SCE_OFS_RSVD_B 12'h018
`define SCE_OFS_RSVD_C 12'h01C
`define SCE_OFS_POWER 12'h020

// ********************************************************************
// event, mask and condition bit positions
// ********************************************************************
`define SCE_BIT_STATUS 0
`define SCE_BIT_DETECT1 1
`define SCE_BIT_DETECT2 2
`define SCE_BIT_POWER 3
`define SCE_EVENT_BITS 4
`define SCE_DETECT_ON 2'h3

// ********************************************************************
// reset values
// ********************************************************************
`define SCE_FLAGS_RESET 4'h0
`define SCE_ENABLE_RESET 4'h0
`define SCE_WORD_ZERO 32'h00000000

`endif

// [src/pin_edge_sync.v]
`timescale 1ns/1ns
// ********************************************************************
// two-stage synchroniser with edge detection per bit
// ********************************************************************
module pin_edge_sync #(
  parameter WIDTH = 5
) (
  input wire refClk,
  input wire reset,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [WIDTH-1:0] prev_q;

  always @(posedge refClk) begin
    if (reset) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// [verification/sce_asserts.sv]
`timescale 1ns/1ns
module sce_asserts (
  input wire refClk,
  input wire reset,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgReadData,
  input wire memRead,
  input wire [31:0] memAddr,
  input wire [31:0] memReadData,
  input wire memReadValid,
  input wire memHit,
  input wire interruptsEnabled,
  input wire status_change_interrupt
);
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge refClk); endclocking
  default disable iff (reset);
  a_valid_after_read: assert property (memRead && memHit |=> memReadValid)
    else $error("read answer missing");
  a_no_stray_valid: assert property (!(memRead && memHit) |=> !memReadValid)
    else $error("answer without read");
  a_data_holds: assert property (!(memRead && memHit) |=> $stable(memReadData))
    else $error("read word changed without read");
  a_reset_clears: assert property (disable iff (1'b0)
    reset |=> !status_change_interrupt && memReadData == 32'h00000000)
    else $error("reset did not clear outputs");
  a_upper_bits_zero: assert property (
    memRead && memHit && memAddr[11:4] == 8'h00 |=> memReadData[31:4] == 28'h0)
    else $error("upper register bits not zero");
  a_irq_needs_enable: assert property (
    !interruptsEnabled |=> !status_change_interrupt)
    else $error("interrupt while disabled");
  a_cfg_base_low: assert property (
    cfgRead && cfgAddr == 8'h10 |=> cfgReadData[11:0] == 12'h000)
    else $error("base low bits not zero");
  a_cfg_other_zero: assert property (
    cfgRead && cfgAddr != 8'h10 |=> cfgReadData == 32'h00000000)
    else $error("unmapped config read not zero");
endmodule
bind socket_status_change_events sce_asserts chk (.refClk(refClk),
  .reset(reset), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
  .cfgReadData(cfgReadData), .memRead(memRead), .memAddr(memAddr),
  .memReadData(memReadData), .memReadValid(memReadValid), .memHit(memHit),
  .interruptsEnabled(interruptsEnabled),
  .status_change_interrupt(status_change_interrupt));

// [verification/socket_pins.sv]
`timescale 1ns/1ns
module socket_pins (
  input wire refClk,
  output reg [4:0] pinLevels
);
  // ****************
  // socket pin levels: reset, power, detect2, detect1, status
  // ****************
  initial pinLevels = 5'h00;
  task drive(input [4:0] v);
    begin
      @(negedge refClk);
      pinLevels <= v;
    end
  endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  localparam [31:0] BASE = 32'h40000000;
  reg refClk, reset, cfgWrite, cfgRead, memWrite, memRead;
  reg cardIsCardBus, interruptsEnabled;
  reg [7:0] cfgAddr;
  reg [31:0] cfgWriteData, memAddr, memWriteData;
  reg [3:0] memByteEnable;
  wire [31:0] cfgReadData, memReadData;
  wire memReadValid, memHit, irq;
  wire [31:0] setupW, powerW;
  wire [4:0] pins;
  integer mismatches, checks_done, b;
  reg [3:0] en [0:3];
`define CHK(n, e, g) begin checks_done = checks_done + 1; if ((g) !== (e)) \
  begin mismatches = mismatches + 1; \
  $display("Error %s expected %h seen %h", n, e, g); end end
  // ****************
  // design and far side
  // ****************
  socket_pins sock (.refClk(refClk), .pinLevels(pins));
  socket_status_change_events DUT (.refClk(refClk), .reset(reset),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr),
    .memByteEnable(memByteEnable), .memWriteData(memWriteData),
    .memReadData(memReadData), .memReadValid(memReadValid),
    .memHit(memHit), .card_status_field(pins[0]),
    .detect_one_status(pins[1]), .detect_two_status(pins[2]),
    .power_cycle_status(pins[3]), .cardResetPin(pins[4]),
    .cardIsCardBus(cardIsCardBus), .interruptsEnabled(interruptsEnabled),
    .status_change_interrupt(irq), .setupOut(setupW), .powerOut(powerW));
  initial begin
    refClk = 0;
    forever #10 refClk = ~refClk;
  end
  task cfgOp(input w, input [7:0] a, input [31:0] d);
    begin
      @(negedge refClk);
      {cfgWrite, cfgRead, cfgAddr, cfgWriteData} = {w, !w, a, d};
      @(negedge refClk);
      {cfgWrite, cfgRead} = 2'b00;
    end
  endtask
  task memWr(input [11:0] o, input [31:0] d);
    begin
      @(negedge refClk);
      {memAddr, memWriteData, memWrite} = {BASE + o, d, 1'b1};
      @(negedge refClk);
      memWrite = 0;
    end
  endtask
  task memChk(input [11:0] o, input [31:0] e);
    begin
      @(negedge refClk);
      {memAddr, memRead} = {BASE + o, 1'b1};
      @(negedge refClk);
      memRead = 0;
      `CHK("valid", 1'b1, memReadValid)
      `CHK("word", e, memReadData)
    end
  endtask
  task step(input [4:0] v, input [3:0] e);
    begin
      sock.drive(v);
      repeat (6) @(negedge refClk);
      memChk(12'h000, {28'h0, e});
      memWr(12'h000, 32'h0000000F);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task t_base;
    begin
      memChk(12'h000, 32'h00000000);
      memChk(12'h004, 32'h00000000);
      cfgOp(1'b0, 8'h10, 0);
      `CHK("base", BASE, cfgReadData)
      cfgOp(1'b0, 8'h14, 0);
      `CHK("cfg", 32'h00000000, cfgReadData)
      $display("base done");
    end
  endtask
  task t_pins;
    begin
      for (b = 1; b < 4; b = b + 1) begin
        sock.drive(pins | (5'h01 << b));
        repeat (6) @(negedge refClk);
        memWr(12'h000, 32'h00000000);
        memChk(12'h000, 32'h1 << b);
        `CHK("irq", 1'b0, irq)
        memWr(12'h000, 32'h1 << b);
        memChk(12'h000, 32'h0);
      end
      memChk(12'h008, 32'h0000000E);
      step(5'h00, 4'hE);
      cardIsCardBus = 1;
      step(5'h01, 4'h1);
      step(5'h00, 4'h0);
      cardIsCardBus = 0;
      step(5'h01, 4'h1);
      step(5'h00, 4'h1);
      sock.drive(5'h12);
      step(5'h12, 4'h2);
      step(5'h02, 4'h2);
      step(5'h00, 4'h2);
      $display("pins done");
    end
  endtask
  task t_regs;
    begin
      memWr(12'h00C, 32'hFFFFFFFF);
      memChk(12'h000, 32'h0000000F);
      memByteEnable = 4'hE;
      memWr(12'h010, 32'h12345678);
      memWr(12'h004, 32'hFFFFFFFF);
      memWr(12'h000, 32'hFFFFFFFF);
      memByteEnable = 4'hF;
      memWr(12'h020, 32'hA5A5A5A5);
      memWr(12'h014, 32'hFFFFFFFF);
      memWr(12'h018, 32'hFFFFFFFF);
      memWr(12'h01C, 32'hFFFFFFFF);
      memWr(12'h008, 32'hFFFFFFFF);
      memChk(12'h004, 32'h00000000);
      memChk(12'h000, 32'h0000000F);
      memChk(12'h010, 32'h12345600);
      `CHK("setup", 32'h12345600, setupW)
      memChk(12'h020, 32'hA5A5A5A5);
      `CHK("power", 32'hA5A5A5A5, powerW)
      memChk(12'h00C, 32'h00000000);
      @(negedge refClk);
      {memAddr, memRead} = {32'h00000000, 1'b1};
      @(negedge refClk);
      `CHK("hit", 1'b0, memHit)
      memRead = 0;
      `CHK("miss", 1'b0, memReadValid)
      memWr(12'h000, 32'hFFFFFFFF);
      memChk(12'h000, 32'h00000000);
      memWr(12'h004, 32'hFFFFFFFF);
      memChk(12'h004, 32'h0000000F);
      memWr(12'h004, 32'h00000000);
      $display("regs done");
    end
  endtask
  task t_irq;
    begin
      {en[0], en[1], en[2], en[3]} = {4'h1, 4'h6, 4'h6, 4'h8};
      interruptsEnabled = 1;
      for (b = 0; b < 4; b = b + 1) begin
        memWr(12'h00C, 32'h1 << b);
        memWr(12'h004, {28'h0, en[b]});
        @(negedge refClk);
        `CHK("irq", 1'b1, irq)
        interruptsEnabled = 0;
        repeat (2) @(negedge refClk);
        `CHK("irq", 1'b0, irq)
        interruptsEnabled = 1;
        memWr(12'h000, 32'h0000000F);
        @(negedge refClk);
        `CHK("irq", 1'b0, irq)
        memWr(12'h004, 32'h0);
      end
      memWr(12'h00C, 32'h00000002);
      memWr(12'h004, 32'h00000002);
      repeat (2) @(negedge refClk);
      `CHK("irq", 1'b0, irq)
      $display("irq done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  initial begin
    {reset, cfgWrite, cfgRead, memWrite, memRead} = 5'b10000;
    {cardIsCardBus, interruptsEnabled, cfgAddr, memByteEnable} = 14'h000F;
    {cfgWriteData, memAddr, memWriteData} = 96'h0;
    {mismatches, checks_done} = 64'h0;
    repeat (5) @(negedge refClk);
    reset = 0;
    cfgOp(1'b1, 8'h10, BASE);
    t_base;
    t_pins;
    t_regs;
    t_irq;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge refClk);
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
